/* File: rtl/apcs_clock_select.sv */
// Clock source selection for the serial audio ports, APB slave
`timescale 1ns/1ps
`include "apcs_params.svh"

// Function
// - Transmitter clock select field, bits 5:4
// - Receiver uses synth A; synths hidden
// - Transmitter carrying receiver data uses synth A
// - Transmitter rate follows routed data source
// - Converter data: port word clock or register
// - Primary receive master/slave from bit 5
// - Primary receive slave uses own pins
// - Primary receive master clock select bits 7:6
// - Receiver enabled forces primary receive to pin
// - Primary transmit master/slave from bit 8
// - Primary transmit slave bit/word clock pins
// - Primary transmit receiver data uses synth A
// - Primary transmit secondary data follows converter
// - Secondary port shared clocks, bit 5 mode
// - Secondary slave uses own clock pins
// - Secondary carrying receiver data uses synth A
// - Receiver up restricts secondary to pins
// - Secondary master clock select bits 7:6
// - Manual override bypasses every automatic clock source choice except the transmitter rate reference
// - Override disables converter synth A pick
module apcs_clock_select
  import apcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        receiver_enable_pin,
  output apcs_sel_s        sel_out,
  output logic             conv_synth_a_auto
);

  // ************************************************************
  // APB register file
  // ************************************************************
  logic [8:0] clock_source_select_reg;
  logic [8:0] prxctl_reg;
  logic [8:0] secctl_reg;
  logic [8:0] route_reg;
  logic       rx_en_meta_reg;
  logic       rx_en_reg;
  logic       acc;
  logic       hit;
  logic [31:0] rdata_next;

  assign acc = psel & penable & ~pready;

  always_comb begin
    hit = 1'b1;
    rdata_next = 32'h0;
    unique case (paddr)
      `APCS_ADDR_CLOCK_SOURCE_SELECT: rdata_next = {23'h0, clock_source_select_reg};
      `APCS_ADDR_PRXCTL: rdata_next = {23'h0, prxctl_reg};
      `APCS_ADDR_SECCTL: rdata_next = {23'h0, secctl_reg};
      `APCS_ADDR_ROUTE:  rdata_next = {23'h0, route_reg};
      `APCS_ADDR_STATUS: rdata_next = {16'h0, rx_en_reg, sel_out};
      default:           hit = 1'b0;
    endcase
  end

  // One wait state: answer in the cycle after the access phase opens
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= (acc & ~pwrite) ? rdata_next : 32'h0;
    end
  end

  // Write lands on the edge that completes the transfer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clock_source_select_reg <= `APCS_CLOCK_SOURCE_SELECT_RST;
      prxctl_reg <= `APCS_PRXCTL_RST;
      secctl_reg <= `APCS_SECCTL_RST;
      route_reg  <= `APCS_ROUTE_RST;
    end else if (psel && penable && pready && pwrite) begin
      unique case (paddr)
        `APCS_ADDR_CLOCK_SOURCE_SELECT: clock_source_select_reg <= pwdata[8:0];
        `APCS_ADDR_PRXCTL: prxctl_reg <= pwdata[8:0];
        `APCS_ADDR_SECCTL: secctl_reg <= pwdata[8:0];
        `APCS_ADDR_ROUTE:  route_reg  <= pwdata[8:0];
        default: ;
      endcase
    end
  end

  // Receiver enable is a pin from another domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_en_meta_reg <= 1'b0;
      rx_en_reg      <= 1'b0;
    end else begin
      rx_en_meta_reg <= receiver_enable_pin;
      rx_en_reg      <= rx_en_meta_reg;
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  logic       man;
  logic [1:0] tx_fld;
  logic [1:0] adc_fld;
  logic [1:0] prx_fld;
  logic [1:0] sec_fld;
  apcs_dsrc_e tx_src;
  apcs_dsrc_e ptx_src;
  apcs_dsrc_e sec_src;
  logic       ptx_conv;
  logic       conv_dir;
  logic       ptx_master_bit;

  assign man      = clock_source_select_reg[`APCS_MAN_BIT];
  assign tx_fld   = clock_source_select_reg[`APCS_TXSEL_LSB +: 2];
  assign adc_fld  = clock_source_select_reg[`APCS_ADCSEL_LSB +: 2];
  assign prx_fld  = prxctl_reg[`APCS_MSSEL_LSB +: 2];
  assign sec_fld  = secctl_reg[`APCS_MSSEL_LSB +: 2];
  assign tx_src   = apcs_dsrc_e'(route_reg[`APCS_RT_TX_LSB +: 2]);
  assign ptx_src  = apcs_dsrc_e'(route_reg[`APCS_RT_PTX_LSB +: 2]);
  assign sec_src  = apcs_dsrc_e'(route_reg[`APCS_RT_SEC_LSB +: 2]);
  assign ptx_conv = route_reg[`APCS_RT_PTXCONV_BIT];
  assign conv_dir = route_reg[`APCS_RT_CONV_LSB +: 2] == 2'h0;
  assign ptx_master_bit = prxctl_reg[`APCS_PTX_MASTER_BIT];

  // ************************************************************
  // Selection
  // ************************************************************
  apcs_sel_s sel_next;
  logic [1:0] conv_clk;
  logic       conv_auto_next;

  always_comb begin
    sel_next = '0;
    // Converter clock, restricted to pins while receiver is up
    conv_clk = adc_fld;
    if (!man && rx_en_reg &&
        (adc_fld == `APCS_SRC_SYNA || adc_fld == `APCS_SRC_SYNB))
      conv_clk = `APCS_SRC_CMCLK;
    conv_auto_next = !man && conv_dir;

    sel_next.dat_tx_clock_select = tx_fld;
    if (!man) begin
      if (tx_src == APCS_DSRC_DIR)
        sel_next.dat_tx_clock_select = `APCS_SRC_SYNA;
      else if (rx_en_reg && (tx_fld == `APCS_SRC_SYNA ||
                             tx_fld == `APCS_SRC_SYNB))
        sel_next.dat_tx_clock_select = `APCS_SRC_MCLK;
    end

    sel_next.dat_tx_rate_from_reg = 1'b0;
    unique case (tx_src)
      APCS_DSRC_DIR: sel_next.dat_tx_rate_ref = APCS_RATE_FRAME;
      APCS_DSRC_PRX: sel_next.dat_tx_rate_ref = APCS_RATE_PRXWC;
      APCS_DSRC_SRX: sel_next.dat_tx_rate_ref = APCS_RATE_SRXWC;
      APCS_DSRC_CONV: begin
        sel_next.dat_tx_rate_ref = APCS_RATE_PTXWC;
        sel_next.dat_tx_rate_from_reg = !ptx_conv;
      end
    endcase

    sel_next.primary_rx_master = prxctl_reg[`APCS_MASTER_BIT];
    // Codes 00 and 11 both mean the master clock pin
    sel_next.primary_rx_master_clock =
      (prx_fld == 2'h0) ? `APCS_SRC_MCLK : prx_fld;
    if (!man && rx_en_reg)
      sel_next.primary_rx_master_clock = `APCS_SRC_MCLK;

    sel_next.primary_tx_master = ptx_master_bit;
    sel_next.primary_tx_bclk_from_rx = conv_clk == `APCS_SRC_MCLK;
    sel_next.primary_tx_master_clock = conv_clk;
    if (!man) begin
      if (ptx_src == APCS_DSRC_DIR)
        sel_next.primary_tx_master_clock = `APCS_SRC_SYNA;
      else if (ptx_src == APCS_DSRC_SRX)
        sel_next.primary_tx_master_clock = conv_clk;
    end

    sel_next.secondary_master = secctl_reg[`APCS_MASTER_BIT];
    sel_next.secondary_master_clock = sec_fld;
    if (!man) begin
      if (sec_src == APCS_DSRC_DIR)
        sel_next.secondary_master_clock = `APCS_SRC_SYNA;
      else if (rx_en_reg && (sec_fld == `APCS_SRC_SYNA ||
                             sec_fld == `APCS_SRC_SYNB))
        sel_next.secondary_master_clock = `APCS_SRC_MCLK;
    end
  end

  // Registered selects avoid glitches on the clock mux controls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_out           <= '0;
      conv_synth_a_auto <= 1'b0;
    end else begin
      sel_out           <= sel_next;
      conv_synth_a_auto <= conv_auto_next;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_write_clock_source_select;
    psel && penable && pwrite && pready &&
      paddr == `APCS_ADDR_CLOCK_SOURCE_SELECT;
  endsequence

  a_tx_recv_syna: assert property (@(posedge clk) disable iff (sys_rst)
    !man && tx_src == APCS_DSRC_DIR |=>
      sel_out.dat_tx_clock_select == `APCS_SRC_SYNA)
    else $error("tx not on synth a for receiver data");
  a_tx_no_synth: assert property (@(posedge clk) disable iff (sys_rst)
    !man && rx_en_reg && tx_src != APCS_DSRC_DIR |=>
      sel_out.dat_tx_clock_select[1] == sel_out.dat_tx_clock_select[0])
    else $error("synth offered while receiver active");
  a_tx_rate_ref: assert property (@(posedge clk) disable iff (sys_rst)
    tx_src == APCS_DSRC_PRX |=> sel_out.dat_tx_rate_ref == APCS_RATE_PRXWC)
    else $error("tx rate ref wrong");
  a_rate_reg_pick: assert property (@(posedge clk) disable iff (sys_rst)
    tx_src == APCS_DSRC_CONV |=> sel_out.dat_tx_rate_from_reg == !$past(ptx_conv))
    else $error("converter rate pick wrong");
  a_prx_forced: assert property (@(posedge clk) disable iff (sys_rst)
    !man && rx_en_reg |=> sel_out.primary_rx_master_clock == `APCS_SRC_MCLK)
    else $error("primary rx not forced to pin");
  a_ptx_syna: assert property (@(posedge clk) disable iff (sys_rst)
    !man && ptx_src == APCS_DSRC_DIR |=>
      sel_out.primary_tx_master_clock == `APCS_SRC_SYNA)
    else $error("primary tx not on synth a");
  a_sec_syna: assert property (@(posedge clk) disable iff (sys_rst)
    !man && sec_src == APCS_DSRC_DIR |=>
      sel_out.secondary_master_clock == `APCS_SRC_SYNA)
    else $error("secondary not on synth a");
  a_man_follow: assert property (@(posedge clk) disable iff (sys_rst)
    man |=> sel_out.secondary_master_clock == $past(sec_fld))
    else $error("override not followed");
  a_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
    s_write_clock_source_select |=> clock_source_select_reg == $past(pwdata[8:0]) ##1
      (!man || sel_out.dat_tx_clock_select == $past(tx_fld)))
    else $error("select did not update");
  a_mode_bit: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> sel_out.primary_rx_master == $past(prxctl_reg[5]))
    else $error("primary rx mode bit lost");

  // ************************************************************
  // Bus timing and field checks
  // ************************************************************
  sequence s_access_open;
    psel && penable && !pready;
  endsequence

  sequence s_read_clock_source_select;
    s_access_open ##0 (!pwrite && paddr == `APCS_ADDR_CLOCK_SOURCE_SELECT);
  endsequence

  sequence s_pin_high;
    receiver_enable_pin;
  endsequence

  // Bus handshake: one wait state, answer stands one cycle
  a_one_wait: assert property (@(posedge clk) disable iff (sys_rst)
    s_access_open |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready held too long");
  a_err_with_rdy: assert property (@(posedge clk) disable iff (sys_rst)
    pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_no_err_map: assert property (@(posedge clk) disable iff (sys_rst)
    s_access_open ##0 paddr == `APCS_ADDR_ROUTE |=> !pslverr)
    else $error("error on mapped register");
  a_read_clock_source_select: assert property (@(posedge clk) disable iff (sys_rst)
    s_read_clock_source_select |=> prdata == {23'h0, $past(clock_source_select_reg)})
    else $error("clock select readback wrong");

  // Transmitter clock and rate reference
  a_tx_field: assert property (@(posedge clk) disable iff (sys_rst)
    !man && !rx_en_reg && tx_src != APCS_DSRC_DIR |=>
      sel_out.dat_tx_clock_select == $past(tx_fld))
    else $error("tx select not following field");
  a_tx_man_field: assert property (@(posedge clk) disable iff (sys_rst)
    man |=> sel_out.dat_tx_clock_select == $past(tx_fld))
    else $error("tx select not manual");
  a_rate_frame: assert property (@(posedge clk) disable iff (sys_rst)
    tx_src == APCS_DSRC_DIR |=> sel_out.dat_tx_rate_ref == APCS_RATE_FRAME)
    else $error("tx rate not from frame clock");
  a_rate_srx: assert property (@(posedge clk) disable iff (sys_rst)
    tx_src == APCS_DSRC_SRX |=> sel_out.dat_tx_rate_ref == APCS_RATE_SRXWC)
    else $error("tx rate not from secondary");
  a_rate_ptx: assert property (@(posedge clk) disable iff (sys_rst)
    tx_src == APCS_DSRC_CONV |=>
      sel_out.dat_tx_rate_ref == APCS_RATE_PTXWC)
    else $error("tx rate not from primary tx");
  a_rate_no_reg: assert property (@(posedge clk) disable iff (sys_rst)
    tx_src != APCS_DSRC_CONV |=> !sel_out.dat_tx_rate_from_reg)
    else $error("rate register used wrongly");

  // Primary ports
  a_prx_code_0: assert property (@(posedge clk) disable iff (sys_rst)
    (man || !rx_en_reg) && prx_fld == 2'h0 |=>
      sel_out.primary_rx_master_clock == `APCS_SRC_MCLK)
    else $error("primary rx code zero not pin");
  a_prx_field: assert property (@(posedge clk) disable iff (sys_rst)
    (man || !rx_en_reg) && prx_fld != 2'h0 |=>
      sel_out.primary_rx_master_clock == $past(prx_fld))
    else $error("primary rx not following field");
  a_ptx_mode: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> sel_out.primary_tx_master == $past(ptx_master_bit))
    else $error("primary tx mode bit lost");
  a_ptx_bclk_pin: assert property (@(posedge clk) disable iff (sys_rst)
    man || !rx_en_reg |=>
      sel_out.primary_tx_bclk_from_rx ==
        ($past(adc_fld) == `APCS_SRC_MCLK))
    else $error("primary tx bit clock pin wrong");
  a_ptx_conv_clk: assert property (@(posedge clk) disable iff (sys_rst)
    !man && !rx_en_reg && ptx_src == APCS_DSRC_SRX |=>
      sel_out.primary_tx_master_clock == $past(adc_fld))
    else $error("primary tx not on converter clock");
  a_ptx_man_conv: assert property (@(posedge clk) disable iff (sys_rst)
    man |=> sel_out.primary_tx_master_clock == $past(adc_fld))
    else $error("primary tx not manual");
  a_ptx_no_synth: assert property (@(posedge clk) disable iff (sys_rst)
    !man && rx_en_reg && ptx_src != APCS_DSRC_DIR |=>
      sel_out.primary_tx_master_clock[1] ==
        sel_out.primary_tx_master_clock[0])
    else $error("primary tx on synth while receiver up");

  // Secondary port
  a_sec_mode: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> sel_out.secondary_master == $past(secctl_reg[`APCS_MASTER_BIT]))
    else $error("secondary mode bit lost");
  a_sec_field: assert property (@(posedge clk) disable iff (sys_rst)
    !man && !rx_en_reg && sec_src != APCS_DSRC_DIR |=>
      sel_out.secondary_master_clock == $past(sec_fld))
    else $error("secondary not following field");
  a_sec_no_synth: assert property (@(posedge clk) disable iff (sys_rst)
    !man && rx_en_reg && sec_src != APCS_DSRC_DIR |=>
      sel_out.secondary_master_clock[1] == sel_out.secondary_master_clock[0])
    else $error("secondary on synth while receiver up");

  // Converter auto pick and receiver synchroniser
  a_conv_auto: assert property (@(posedge clk) disable iff (sys_rst)
    !man && conv_dir |=> conv_synth_a_auto)
    else $error("converter auto pick missing");
  a_conv_no_auto: assert property (@(posedge clk) disable iff (sys_rst)
    man |=> !conv_synth_a_auto)
    else $error("converter auto pick under override");
  // Two stages exactly; a longer path would delay the restrictions
  a_rx_sync_hi: assert property (@(posedge clk) disable iff (sys_rst)
    s_pin_high |=> ##1 rx_en_reg)
    else $error("receiver enable not synchronised");
  a_rx_sync_lo: assert property (@(posedge clk) disable iff (sys_rst)
    !receiver_enable_pin |=> ##1 !rx_en_reg)
    else $error("receiver disable not synchronised");

endmodule

/* File: rtl/apcs_params.svh */
// Offsets, field positions, reset values and codes for the clock select block
`ifndef APCS_PARAMS_SVH
`define APCS_PARAMS_SVH
// Register indexes; the byte address is four times the index
`define APCS_IDX_CLOCK_SOURCE_SELECT    8'h08
`define APCS_IDX_PRXCTL    8'h09
`define APCS_IDX_SECCTL    8'h0b
`define APCS_ADDR_CLOCK_SOURCE_SELECT   ({2'b00, `APCS_IDX_CLOCK_SOURCE_SELECT, 2'b00})
`define APCS_ADDR_PRXCTL   ({2'b00, `APCS_IDX_PRXCTL, 2'b00})
`define APCS_ADDR_SECCTL   ({2'b00, `APCS_IDX_SECCTL, 2'b00})
`define APCS_ADDR_ROUTE    12'h040
`define APCS_ADDR_STATUS   12'h044
`define APCS_CLOCK_SOURCE_SELECT_RST    9'h010
`define APCS_PRXCTL_RST    9'h000
`define APCS_SECCTL_RST    9'h0c0
`define APCS_ROUTE_RST     9'h000
`define APCS_TXSEL_LSB     4
`define APCS_MAN_BIT       6
`define APCS_MSSEL_LSB     6
`define APCS_MASTER_BIT    5
`define APCS_ADCSEL_LSB    2
`define APCS_RT_TX_LSB     0
`define APCS_RT_PTX_LSB    2
`define APCS_RT_SEC_LSB    4
`define APCS_RT_PTXCONV_BIT 6
`define APCS_RT_CONV_LSB   7
`define APCS_PTX_MASTER_BIT 8
`define APCS_SRC_CMCLK     2'h0
`define APCS_SRC_SYNA      2'h1
`define APCS_SRC_SYNB      2'h2
`define APCS_SRC_MCLK      2'h3
`endif

/* File: rtl/apcs_pkg.sv */
// Types shared by the audio port clock select block
package apcs_pkg;
  // Routed data sources
  typedef enum logic [1:0] {
    APCS_DSRC_DIR  = 2'h0,
    APCS_DSRC_PRX  = 2'h1,
    APCS_DSRC_SRX  = 2'h2,
    APCS_DSRC_CONV = 2'h3
  } apcs_dsrc_e;
  typedef enum logic [1:0] {
    APCS_RATE_FRAME = 2'h0,
    APCS_RATE_PRXWC = 2'h1,
    APCS_RATE_SRXWC = 2'h2,
    APCS_RATE_PTXWC = 2'h3
  } apcs_rate_e;
  typedef struct packed {
    logic [1:0] dat_tx_clock_select;
    apcs_rate_e dat_tx_rate_ref;
    logic       dat_tx_rate_from_reg;
    logic [1:0] primary_rx_master_clock;
    logic       primary_rx_master;
    logic [1:0] primary_tx_master_clock;
    logic       primary_tx_master;
    logic       primary_tx_bclk_from_rx;
    logic [1:0] secondary_master_clock;
    logic       secondary_master;
  } apcs_sel_s;
endpackage

/* File: verif/apcs_clock_select_tb.sv */
// Self-checking bench for the audio port clock select block
`timescale 1ns/1ps
`include "apcs_params.svh"

module apcs_clock_select_tb
  import apcs_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_en = 1'b0;
  apcs_sel_s   sel_out;
  logic        conv_synth_a_auto;
  logic [31:0] rdat;
  logic        rerr;
  int          bad_count = 0;
  int          comparisons = 0;

  always #12.5 clk = ~clk;

  apcs_clock_select dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receiver_enable_pin(rx_en),
    .sel_out(sel_out), .conv_synth_a_auto(conv_synth_a_auto)
  );

  // ****************************************
  // Access tasks
  // ****************************************
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; reads see pre-edge register values
  task apb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // Pin path adds two sync stages, so allow four edges
  task settle;
    repeat (4) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`APCS_ADDR_CLOCK_SOURCE_SELECT, 32'h010);
    rd(`APCS_ADDR_PRXCTL, 32'h000);
    rd(`APCS_ADDR_SECCTL, 32'h0c0);
    apb(1'b0, 12'h030, 32'h0);
    chk(rdat, 32'h0);
    chk(32'(rerr), 32'h1);
    wr(`APCS_ADDR_ROUTE, 32'h03f);
    for (int v = 0; v < 4; v++) begin
      wr(`APCS_ADDR_CLOCK_SOURCE_SELECT, 32'(v) << 4);
      settle();
      chk(32'(sel_out.dat_tx_clock_select), 32'(v));
      chk(32'(sel_out.dat_tx_rate_from_reg), 32'h1);
    end
    wr(`APCS_ADDR_ROUTE, 32'h03c);
    settle();
    chk(32'(sel_out.dat_tx_clock_select), 32'h1);
    for (int s = 0; s < 3; s++) begin
      wr(`APCS_ADDR_ROUTE, 32'h03c | 32'(s));
      settle();
      chk(32'(sel_out.dat_tx_rate_ref), 32'(s));
    end
    wr(`APCS_ADDR_ROUTE, 32'h07f);
    settle();
    chk(32'(sel_out.dat_tx_rate_ref), 32'h3);
    chk(32'(sel_out.dat_tx_rate_from_reg), 32'h0);
    wr(`APCS_ADDR_PRXCTL, 32'h160);
    wr(`APCS_ADDR_SECCTL, 32'h0e0);
    rd(`APCS_ADDR_SECCTL, 32'h0e0);
    wr(`APCS_ADDR_CLOCK_SOURCE_SELECT, 32'h00c);
    settle();
    chk(32'(sel_out.primary_rx_master), 32'h1);
    chk(32'(sel_out.primary_tx_master), 32'h1);
    chk(32'(sel_out.secondary_master), 32'h1);
    chk(32'(sel_out.primary_rx_master_clock), 32'h1);
    chk(32'(sel_out.primary_tx_bclk_from_rx), 32'h1);
    wr(`APCS_ADDR_PRXCTL, 32'h080);
    wr(`APCS_ADDR_ROUTE, 32'h078);
    wr(`APCS_ADDR_CLOCK_SOURCE_SELECT, 32'h008);
    settle();
    chk(32'(sel_out.primary_rx_master), 32'h0);
    chk(32'(sel_out.primary_rx_master_clock), 32'h2);
    chk(32'(sel_out.primary_tx_master_clock), 32'h2);
    wr(`APCS_ADDR_ROUTE, 32'h040);
    settle();
    chk(32'(sel_out.primary_tx_master_clock), 32'h1);
    chk(32'(sel_out.secondary_master_clock), 32'h1);
    chk(32'(conv_synth_a_auto), 32'h1);
    // Receiver up: synthesised clocks withdrawn from other consumers, then kept under manual override
    rx_en <= 1'b1;
    wr(`APCS_ADDR_ROUTE, 32'h013);
    wr(`APCS_ADDR_SECCTL, 32'h040);
    wr(`APCS_ADDR_CLOCK_SOURCE_SELECT, 32'h020);
    settle();
    chk(32'(sel_out.primary_rx_master_clock), 32'h3);
    chk(32'(sel_out.secondary_master_clock), 32'h3);
    chk(32'(sel_out.dat_tx_clock_select), 32'h3);
    wr(`APCS_ADDR_SECCTL, 32'h000);
    settle();
    chk(32'(sel_out.secondary_master_clock), 32'h0);
    wr(`APCS_ADDR_ROUTE, 32'h010);
    wr(`APCS_ADDR_CLOCK_SOURCE_SELECT, 32'h060);
    wr(`APCS_ADDR_SECCTL, 32'h040);
    settle();
    chk(32'(sel_out.dat_tx_clock_select), 32'h2);
    chk(32'(sel_out.primary_rx_master_clock), 32'h2);
    chk(32'(sel_out.secondary_master_clock), 32'h1);
    chk(32'(conv_synth_a_auto), 32'h0);
    report_and_stop();
  end
endmodule
